// ---- include/sewt_pkg.sv ----
// Shared constants and carrier types for the secure EEPROM two-wire target.
// Assumes a 40 MHz core clock and a host-driven serial clock on its own domain.
package sewt_pkg;

  // ****************************************************************
  // Memory organisation
  // ****************************************************************
  localparam int unsigned ZONE_COUNT     = 8;
  localparam int unsigned ZONE_BITS      = 1024;
  localparam int unsigned ZONE_BYTES     = ZONE_BITS / 8;
  localparam int unsigned WORD_BITS      = 8;
  localparam int unsigned ZONE_IDX_W     = 3;
  localparam int unsigned OFFSET_W       = 7;
  localparam int unsigned MEM_ADDR_W     = ZONE_IDX_W + OFFSET_W;
  localparam int unsigned FIFO_DEPTH     = 32;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CORE_CLK_KHZ   = 40000;
  localparam int unsigned WRITE_MS_ROOM  = 5;
  localparam int unsigned WRITE_MS_FULL  = 7;
  // Longest time rounds down; room-temperature figure bounds the cycle
  localparam int unsigned WRITE_CYCLES   = WRITE_MS_ROOM * CORE_CLK_KHZ;
  localparam int unsigned WRITE_CNT_W    = 24;

  // ****************************************************************
  // Command byte layout: [7:4] opcode, [2:0] zone
  // ****************************************************************
  localparam logic [3:0] OP_WRITE        = 4'hb;
  localparam logic [3:0] OP_READ         = 4'hc;
  localparam int unsigned CMD_OP_LSB     = 4;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // Event passed from link domain to core domain
  typedef struct packed {
    logic [7:0] data;
    logic       is_cmd;
    logic       is_addr;
  } sewt_word_s;

  // Zone access rights as held in configuration memory
  typedef struct packed {
    logic [7:0] read_ok;
    logic [7:0] write_ok;
  } sewt_rights_s;

endpackage

// ---- rtl/sewt_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
module sewt_fifo
  import sewt_pkg::*;
#(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;

  // Honest full and empty from extended pointers
  assign full      = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr[PW-1:0]];

  // Write pointer and storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      store[wr_ptr[PW-1:0]] <= in_data;
      wr_ptr                <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule // sewt_fifo

// ---- rtl/sewt_target.sv ----
// Two-wire target of a secure serial EEPROM with eight zones.
// Assumes scl is the link clock, sda is open drain with external pull-up.
//
// Contract
// R1 - Data may change only while the clock is low; changes with clock high are bus conditions.
// R2 - The data line is only pulled low or released, never driven high.
// R3 - A falling data edge with clock high is a start and begins a new transfer.
// R4 - A rising data edge with clock high is a stop and ends the transfer.
// R5 - A stop following a read places the device in standby.
// R6 - Every address and data item moves as an eight-bit word.
// R7 - Each received word is acknowledged by pulling data low on the ninth clock.
// R8 - After up to nine recovery clocks, a start resynchronises the device.
// R9 - A stop ending a write starts a self-timed write that finishes within its time limit.
// R10 - User memory is eight zones of 1024 bits.
// R11 - A zone is reachable only when its security rights allow.
// R12 - Zones with equal rights behave as one larger zone; the code keeps every zone separate, each addressed by its own 7-bit offset.
// R13 - All zone access passes through the permission checks fed by configuration settings.
// R14 - Incoming data is sampled on the rising clock edge, outgoing shifted on the falling edge.
// R15 - Commands are not acknowledged while the self-timed write runs.
// R16 - Each zone spans offsets 0 to 127, with zone chosen apart from the offset.
`timescale 1ns/1ps
module sewt_target
  import sewt_pkg::*;
(
  // Core clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Serial link
  input  wire logic         scl,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // Security rights from configuration memory
  input  wire sewt_rights_s rights,
  // Status
  output logic              standby,
  output logic              write_busy,
  output logic              fifo_full
);

  // ****************************************************************
  // Link-domain state (clocked by scl; start and stop toggles by sda edges)
  // ****************************************************************
  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_RECV = 4'b0010,
    LS_SEND = 4'b0100,
    LS_HALT = 4'b1000
  } sewt_link_e;

  sewt_link_e link_st;
  logic [7:0] shift_in;
  logic [3:0] bit_cnt;
  logic [1:0] word_idx;
  logic       drive_low = 1'b0;                           // Defined level before first clock
  logic [7:0] tx_byte;
  logic       word_tgl = 1'b0;                            // Link flops have no reset
  logic [7:0] word_data;
  logic       word_cmd;
  logic       word_addr;
  logic       is_read;
  logic       busy_l1 = 1'b0;
  logic       busy_l2 = 1'b0;
  logic [7:0] rd_l1;
  logic [7:0] rd_l2;
  logic [7:0] rd_data;

  // Start and stop flags, set by sda edges while scl high
  logic       start_tgl = 1'b0;
  logic       stop_tgl = 1'b0;
  logic       start_seen;
  logic       start_ack = 1'b0;

  // Start condition: sda falls with scl high [R3] [R1]
  always_ff @(negedge sda_in) begin
    if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Stop condition: sda rises with scl high [R4] [R1]
  always_ff @(posedge sda_in) begin
    if (scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // Pending start consumed at next scl rise [R8]
  assign start_seen = (start_tgl != start_ack);

  // Busy level into link domain through two flops [R15]
  always_ff @(posedge scl) begin
    busy_l1 <= write_busy;
    busy_l2 <= busy_l1;
    rd_l1   <= rd_data;
    rd_l2   <= rd_l1;
  end

  // Receive on rising scl, eight bits then ack clock [R14] [R6]
  always_ff @(posedge scl) begin
    start_ack <= start_tgl;
    if (start_seen) begin
      link_st  <= busy_l2 ? LS_HALT : LS_RECV;              // [R15] [R8]
      shift_in <= {7'h00, sda_in};
      bit_cnt  <= 4'h1;
      word_idx <= 2'h0;
    end else begin
      case (link_st)
        LS_RECV: begin
          if (bit_cnt == 4'h8) begin
            bit_cnt   <= 4'h0;
            word_data <= shift_in;
            word_cmd  <= (word_idx == 2'h0);
            word_addr <= (word_idx == 2'h1);
            word_tgl  <= ~word_tgl;
            if (word_idx != 2'h2) begin
              word_idx <= word_idx + 2'h1;
            end
            if (word_idx == 2'h1 && is_read) begin
              link_st <= LS_SEND;
            end
          end else begin
            shift_in <= {shift_in[6:0], sda_in};              // [R6]
            bit_cnt  <= bit_cnt + 4'h1;
          end
        end
        LS_SEND: begin
          // Master ack bit on ninth clock; high means stop reading
          if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (sda_in) begin
              link_st <= LS_IDLE;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: begin
          bit_cnt <= 4'h0;
        end
      endcase
    end
  end

  // Read opcode latched from command byte
  always_ff @(posedge scl) begin
    if (link_st == LS_RECV && bit_cnt == 4'h8 && word_idx == 2'h0) begin
      is_read <= (shift_in[7:CMD_OP_LSB] == OP_READ);
    end
  end

  // Output shift and ack on falling scl [R14] [R7]
  always_ff @(negedge scl) begin
    if (link_st == LS_RECV && bit_cnt == 4'h8 && !busy_l2) begin
      drive_low <= 1'b1;                                       // [R7] [R15]
    end else if (link_st == LS_SEND) begin
      if (bit_cnt == 4'h0) begin
        tx_byte   <= {rd_l2[6:0], 1'b0};
        drive_low <= !rd_l2[7];
      end else if (bit_cnt < 4'h8) begin
        tx_byte   <= {tx_byte[6:0], 1'b0};
        drive_low <= !tx_byte[7];
      end else begin
        drive_low <= 1'b0;
      end
    end else begin
      drive_low <= 1'b0;
    end
  end

  // Open drain: output low only, enable when pulling [R2] [R1]
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  // ****************************************************************
  // Crossings into core domain
  // ****************************************************************
  logic [2:0] wt_sync;
  logic [2:0] st_sync;
  logic [2:0] sp_sync;
  logic       word_evt;
  logic       start_evt;
  logic       stop_evt;
  logic [9:0] word_hold1;
  logic [9:0] word_hold2;

  // Toggle synchronisers; only stage two onward is examined
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wt_sync <= 3'h0;
      st_sync <= 3'h0;
      sp_sync <= 3'h0;
    end else begin
      wt_sync <= {wt_sync[1:0], word_tgl};
      st_sync <= {st_sync[1:0], start_tgl};
      sp_sync <= {sp_sync[1:0], stop_tgl};
    end
  end

  // Word data changes on the same scl edge as its toggle; two flops keep it level with the event
  always_ff @(posedge core_clk) begin
    word_hold1 <= {word_data, word_cmd, word_addr};
    word_hold2 <= word_hold1;
  end

  assign word_evt  = wt_sync[2] ^ wt_sync[1];
  assign start_evt = st_sync[2] ^ st_sync[1];
  assign stop_evt  = sp_sync[2] ^ sp_sync[1];

  // ****************************************************************
  // Core: buffering, command decode, memory
  // ****************************************************************
  sewt_word_s fifo_in;
  sewt_word_s fifo_q;
  logic       fifo_in_ready;
  logic       fifo_valid;
  logic       fifo_take;

  assign fifo_in   = sewt_word_s'(word_hold2);
  assign fifo_take = fifo_valid;

  sewt_fifo #(
    .WIDTH ($bits(sewt_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_valid  (word_evt),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_q)
  );

  logic [7:0]            mem [ZONE_COUNT*ZONE_BYTES];     // [R10]
  logic [ZONE_IDX_W-1:0] zone;
  logic [OFFSET_W-1:0]   offset;
  logic                  op_write;
  logic                  op_read;
  logic                  wr_pend;
  logic [7:0]            wr_byte;
  logic [WRITE_CNT_W-1:0] wr_cnt;
  logic                  read_done;
  logic                  allow_rd;
  logic                  allow_wr;

  // Permission per zone from configured rights; zones sharing rights
  // simply share the same grant [R11] [R12] [R13]
  assign allow_rd = rights.read_ok[zone];
  assign allow_wr = rights.write_ok[zone];

  // Command, address and data word decode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zone     <= '0;
      offset   <= '0;
      op_write <= 1'b0;
      op_read  <= 1'b0;
      wr_pend  <= 1'b0;
      wr_byte  <= RESET_BYTE;
    end else if (start_evt) begin
      wr_pend  <= 1'b0;                                        // [R3]
    end else if (fifo_take) begin
      if (fifo_q.is_cmd) begin
        op_write <= (fifo_q.data[7:CMD_OP_LSB] == OP_WRITE);
        op_read  <= (fifo_q.data[7:CMD_OP_LSB] == OP_READ);
        zone     <= fifo_q.data[ZONE_IDX_W-1:0];              // [R16]
      end else if (fifo_q.is_addr) begin
        offset   <= fifo_q.data[OFFSET_W-1:0];                // [R16]
      end else if (op_write && allow_wr) begin
        wr_byte  <= fifo_q.data;                               // [R11]
        wr_pend  <= 1'b1;
      end
    end else if (stop_evt) begin
      wr_pend  <= 1'b0;
    end
  end

  // Read data presented for the link, gated by rights [R11] [R13]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= RESET_BYTE;
    end else begin
      rd_data <= allow_rd ? mem[{zone, offset}] : RESET_BYTE;
    end
  end

  // Self-timed write started by stop after write [R9] [R4]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      write_busy <= 1'b0;
      wr_cnt     <= '0;
    end else if (!write_busy && stop_evt && wr_pend) begin
      write_busy <= 1'b1;
      wr_cnt     <= WRITE_CNT_W'(WRITE_CYCLES - 1);            // [R9]
    end else if (write_busy) begin
      if (wr_cnt == '0) begin
        write_busy <= 1'b0;                                    // [R15]
      end else begin
        wr_cnt <= wr_cnt - 1'b1;
      end
    end
  end

  // Commit to the array at the end of the write cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ZONE_COUNT * ZONE_BYTES; i++) begin
        mem[i] <= RESET_BYTE;
      end
    end else if (write_busy && wr_cnt == '0) begin
      mem[{zone, offset}] <= wr_byte;                          // [R10]
    end
  end

  // Standby after stop following a read; any start wakes [R5]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      standby   <= 1'b1;
      read_done <= 1'b0;
    end else if (start_evt) begin
      standby   <= 1'b0;
      read_done <= 1'b0;
    end else if (stop_evt) begin
      standby   <= op_read;                                    // [R5]
    end
  end

  // FIFO full status
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fifo_full <= 1'b0;
    end else begin
      fifo_full <= !fifo_in_ready;
    end
  end

endmodule // sewt_target

// ---- testbench/sewt_host_model.sv ----
// Bus master model of the two-wire link, clock period 12 ns.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module sewt_host_model (
  // Link
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  // Idle with clock and data high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One clock, data changed only with clock low
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    #6 scl = 1'b1;
    #3 s = sda_line;
    #3 scl = 1'b0;
  endtask
  // Falling data with clock high
  task automatic start();
    sda_low = 1'b0;
    #30 scl = 1'b1;
    #30 sda_low = 1'b1;
    #30 scl = 1'b0;
  endtask
  // Rising data with clock high, then idle
  task automatic stop();
    sda_low = 1'b1;
    #30 scl = 1'b1;
    #30 sda_low = 1'b0;
    #30;
  endtask
  // Eight bits out, most significant first, then the answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // Eight bits in, then master acknowledge or release
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask
  // Nine released clocks, counting high data samples
  task automatic recover(output int highs);
    logic s;
    highs = 0;
    for (int i = 0; i < 9; i++) begin
      clk_bit(1'b1, s);
      highs += (s === 1'b1);
    end
  endtask
endmodule // sewt_host_model

// ---- testbench/sewt_properties.sv ----
// Port checker for the two-wire target, bound to its top module.
// Assumes the host idles the serial clock and data line high.
`timescale 1ns/1ps
module sewt_properties
  import sewt_pkg::*;
(
  // Core side
  input wire logic         core_clk,
  input wire logic         rst_n,
  // Link and status
  input wire logic         scl,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  input wire sewt_rights_s rights,
  input wire logic         standby,
  input wire logic         write_busy,
  input wire logic         fifo_full
);
  logic        oe_hi = 1'b0;
  int unsigned busy_cnt;
  // Pull-down level seen at each rising clock edge
  always_ff @(posedge scl) oe_hi <= sda_oe;
  // Length of the running self-timed write
  always_ff @(posedge core_clk) busy_cnt <= (write_busy && rst_n) ? busy_cnt + 1 : 0;

  open_drain_a: assert property (@(posedge core_clk) disable iff (!rst_n) !sda_out)
    else $error("data line driven high");
  data_stable_a: assert property (@(negedge scl) disable iff (!rst_n) sda_oe == oe_hi)
    else $error("data moved with clock high");
  busy_nack_a: assert property (@(posedge scl) disable iff (!rst_n) write_busy |-> !sda_oe)
    else $error("acknowledge during write");
  busy_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(write_busy) |=> write_busy [*8]) else $error("write cycle cut short");
  busy_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy_cnt <= WRITE_CYCLES + 8) else $error("write cycle too long");
  busy_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(write_busy) |-> scl && sda_in) else $error("write began without stop");
  standby_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(standby) |-> scl && sda_in) else $error("standby without stop");
  standby_free_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(standby) |-> !sda_oe) else $error("line held after stop");
endmodule // sewt_properties

bind sewt_target sewt_properties u_props (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .rights(rights),
  .standby(standby), .write_busy(write_busy), .fifo_full(fifo_full));

// ---- testbench/sewt_target_tb.sv ----
// Self-checking bench for the two-wire target.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module sewt_target_tb
  import sewt_pkg::*;
;
  logic         core_clk, rst_n, sda_out, sda_oe, standby, write_busy, fifo_full;
  logic         scl, sda_low, ack, s;
  wire          sda_line;
  sewt_rights_s rights;
  logic [7:0]   rd;
  int           fail_count, n_checks, highs;

  // Open-drain wire with pull-up
  assign sda_line = !(sda_oe || sda_low);

  sewt_target u_dut (.core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .rights(rights), .standby(standby),
    .write_busy(write_busy), .fifo_full(fifo_full));
  sewt_host_model u_host (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

  // Core clock, 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reference: a denied zone reads as zero, other content is not known here
  function automatic int ref_read(int z);
    return rights.read_ok[z] ? -1 : 0;
  endfunction

  // One byte to the target and its expected answer
  task automatic send(input logic [7:0] b, input logic exp_ack);
    u_host.wr_byte(b, ack);
    chk_bit(ack, exp_ack);
  endtask

  // Read one byte of a zone at a random offset, then stop
  task automatic rd_zone(input int z);
    u_host.start();
    send({OP_READ, 1'b0, 3'(z)}, 1'b1);
    send(8'($urandom) & 8'h7f, 1'b1);
    u_host.rd_byte(1'b1, rd);
    if (ref_read(z) >= 0) chk_byte(rd, 8'(ref_read(z)));
    u_host.stop();
    repeat (8) @(negedge core_clk);
    chk_bit(standby, 1'b1);
  endtask

  // Cut a hang short
  initial begin
    #500us;
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    rights = '0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'hf19b6ec8));
    repeat (10) @(negedge core_clk);
    chk_bit(standby, 1'b1);
    chk_bit(write_busy, 1'b0);
    chk_bit(fifo_full, 1'b0);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      rights = (k == 0) ? 16'($urandom) : 16'h33ff;
      for (int z = 0; z < ZONE_COUNT; z++) rd_zone(z);
    end
    $display("zone read test done");
    u_host.start();
    repeat (3) u_host.clk_bit(1'b0, s);
    u_host.recover(highs);
    chk_bit(highs > 0, 1'b1);
    rd_zone(5);
    $display("recovery test done");
    rights.write_ok[2] = 1'b1;
    u_host.start();
    send({OP_WRITE, 4'h2}, 1'b1);
    send(8'h7f, 1'b1);
    send(8'($urandom), 1'b1);
    u_host.stop();
    repeat (10) @(negedge core_clk);
    chk_bit(write_busy, 1'b1);
    u_host.start();
    send({OP_READ, 4'h2}, 1'b0);
    u_host.stop();
    repeat (10) @(negedge core_clk);
    chk_bit(write_busy, 1'b1);
    $display("write test done");
    report_and_stop();
  end
endmodule // sewt_target_tb
